// ### rtl/tsp_host_port.sv
// Serial control front end: command shift-in, status reply, control and
// tone registers, event flags and the shared interrupt line.
// Assumes the host owns the serial clock and chip select; events and
// power-down levels come from logic on the same core clock.
`timescale 1ns/1ps
`default_nettype none
module tsp_host_port
(
    // Core clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Serial link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic cmd_data,
    output logic reply_data,
    output logic reply_oe,
    // Interrupt pin, open drain
    output logic irq_n_o,
    output logic irq_n_oe,
    // General purpose logic input pin
    input wire logic logic_in,
    // Event pulses and power-down levels
    input wire tsp_pkg::tsp_ev_t ev_i,
    input wire tsp_pkg::tsp_ev_t pd_i,
    // Control outputs
    output logic audio_sw_en,
    output logic sum_sw_close,
    output logic beep_cue_out,
    output logic [tsp_pkg::TONE_W-1:0] tone1_word,
    output logic [tsp_pkg::TONE_W-1:0] tone2_word
);
    // ========================================================
    // Pin synchronisers, two flops each
    logic [tsp_pkg::SYNC_STAGES-1:0] sclk_sy_ff;
    logic [tsp_pkg::SYNC_STAGES-1:0] cs_sy_ff;
    logic [tsp_pkg::SYNC_STAGES-1:0] din_sy_ff;
    logic [tsp_pkg::SYNC_STAGES-1:0] lin_sy_ff;
    logic sclk_d_ff;
    logic rise;
    logic fall;
    logic cs_hi;
    logic din;

    // Only the second stage feeds logic; sclk comes from the host
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sclk_sy_ff <= 2'h0;
            cs_sy_ff <= 2'h3;
            din_sy_ff <= 2'h0;
            lin_sy_ff <= 2'h0;
            sclk_d_ff <= 1'b0;
        end
        else
        begin
            sclk_sy_ff <= {sclk_sy_ff[0], sclk};
            cs_sy_ff <= {cs_sy_ff[0], cs_n};
            din_sy_ff <= {din_sy_ff[0], cmd_data};
            lin_sy_ff <= {lin_sy_ff[0], logic_in};
            sclk_d_ff <= sclk_sy_ff[1];
        end
    end

    // Edge finders on the synchronised serial clock
    assign rise = sclk_sy_ff[1] & ~sclk_d_ff;
    assign fall = ~sclk_sy_ff[1] & sclk_d_ff;
    assign cs_hi = cs_sy_ff[1];
    assign din = din_sy_ff[1];

    // ========================================================
    // Serial engine and registers
    tsp_pkg::tsp_state_t state_ff, nxt_state;
    logic [2:0] bit_ff, nxt_bit;
    logic [7:0] sh_ff, nxt_sh;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [7:0] hi_ff, nxt_hi;
    logic first_ff, nxt_first;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [15:0] tone1_ff, nxt_tone1;
    logic [15:0] tone2_ff, nxt_tone2;
    logic [7:0] rsh_ff, nxt_rsh;
    logic rout_ff, nxt_rout;
    logic roe_ff, nxt_roe;
    logic rd_clr;
    logic [7:0] byte_w;
    logic [7:0] status_w;
    tsp_pkg::tsp_ev_t flag_ff, nxt_flag;
    tsp_pkg::tsp_ev_t en_w;
    logic irq_ff, nxt_irq;

    // Status byte; logic input is the live synchronised level
    always_comb
    begin
        status_w = 8'h00;
        status_w[tsp_pkg::ST_GP] = flag_ff.gp;
        status_w[tsp_pkg::ST_NOTONE] = flag_ff.notone;
        status_w[tsp_pkg::ST_RX] = flag_ff.rx;
        status_w[tsp_pkg::ST_LOGIC] = lin_sy_ff[1];
    end

    // Byte assembled so far, MSB first
    assign byte_w = {sh_ff[6:0], din};

    // Next state of the serial engine
    always_comb
    begin
        nxt_state = state_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_cmd = cmd_ff;
        nxt_hi = hi_ff;
        nxt_first = first_ff;
        nxt_ctrl = ctrl_ff;
        nxt_tone1 = tone1_ff;
        nxt_tone2 = tone2_ff;
        nxt_rsh = rsh_ff;
        nxt_rout = rout_ff;
        nxt_roe = roe_ff;
        rd_clr = 1'b0;
        if (cs_hi)
        begin
            // Deselect ends or abandons the transfer; partial bytes drop
            nxt_state = tsp_pkg::S_IDLE;
            nxt_bit = 3'h0;
            nxt_roe = 1'b0;
        end
        else
        begin
            unique case (state_ff)
                tsp_pkg::S_IDLE:
                begin
                    nxt_state = tsp_pkg::S_CMD;
                    nxt_bit = 3'h0;
                end
                tsp_pkg::S_CMD, tsp_pkg::S_DATA:
                begin
                    if (rise)
                    begin
                        nxt_sh = byte_w;
                        nxt_bit = bit_ff + 3'h1;
                        if (bit_ff == 3'h7 && state_ff == tsp_pkg::S_CMD)
                        begin
                            nxt_cmd = byte_w;
                            nxt_first = 1'b0;
                            nxt_state = tsp_pkg::S_HOLD;
                            if (byte_w == tsp_pkg::CMD_RD_STATUS)
                            begin
                                // First reply bit goes out at once
                                nxt_rsh = status_w;
                                nxt_rout = status_w[7];
                                nxt_roe = 1'b1;
                                rd_clr = 1'b1;
                                nxt_state = tsp_pkg::S_REPLY;
                            end
                            else if (byte_w == tsp_pkg::CMD_WR_CTRL
                                     || byte_w == tsp_pkg::CMD_WR_TONE1
                                     || byte_w == tsp_pkg::CMD_WR_TONE2)
                            begin
                                nxt_state = tsp_pkg::S_DATA;
                            end
                        end
                        else if (bit_ff == 3'h7)
                        begin
                            if (cmd_ff == tsp_pkg::CMD_WR_CTRL)
                            begin
                                nxt_ctrl = byte_w;
                                nxt_state = tsp_pkg::S_HOLD;
                            end
                            else if (!first_ff)
                            begin
                                nxt_hi = byte_w;
                                nxt_first = 1'b1;
                            end
                            else
                            begin
                                // High byte first, then low byte
                                if (cmd_ff == tsp_pkg::CMD_WR_TONE1)
                                    nxt_tone1 = {hi_ff, byte_w};
                                else
                                    nxt_tone2 = {hi_ff, byte_w};
                                nxt_state = tsp_pkg::S_HOLD;
                            end
                        end
                    end
                end
                tsp_pkg::S_REPLY:
                begin
                    if (rise)
                    begin
                        nxt_bit = bit_ff + 3'h1;
                        if (bit_ff == 3'h7)
                        begin
                            nxt_roe = 1'b0;
                            nxt_state = tsp_pkg::S_HOLD;
                        end
                    end
                    else if (fall && bit_ff != 3'h0)
                    begin
                        // Next bit after the host sampled this one
                        nxt_rsh = {rsh_ff[6:0], 1'b0};
                        nxt_rout = rsh_ff[6];
                    end
                end
                tsp_pkg::S_HOLD:
                begin
                    nxt_state = tsp_pkg::S_HOLD;
                end
            endcase
        end
    end

    // Serial engine registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_ff <= tsp_pkg::S_IDLE;
            bit_ff <= 3'h0;
            sh_ff <= 8'h00;
            cmd_ff <= 8'h00;
            hi_ff <= 8'h00;
            first_ff <= 1'b0;
            ctrl_ff <= tsp_pkg::CTRL_RST;
            tone1_ff <= tsp_pkg::TONE_RST;
            tone2_ff <= tsp_pkg::TONE_RST;
            rsh_ff <= 8'h00;
            rout_ff <= 1'b0;
            roe_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            cmd_ff <= nxt_cmd;
            hi_ff <= nxt_hi;
            first_ff <= nxt_first;
            ctrl_ff <= nxt_ctrl;
            tone1_ff <= nxt_tone1;
            tone2_ff <= nxt_tone2;
            rsh_ff <= nxt_rsh;
            rout_ff <= nxt_rout;
            roe_ff <= nxt_roe;
        end
    end

    // ========================================================
    // Event flags and interrupt
    // A powered-down source neither sets nor drives the line
    always_comb
    begin
        en_w.gp = ~pd_i.gp & ctrl_ff[tsp_pkg::CTRL_EN_TMR];
        en_w.notone = ~pd_i.notone & ctrl_ff[tsp_pkg::CTRL_EN_TMR];
        en_w.rx = ~pd_i.rx & ctrl_ff[tsp_pkg::CTRL_EN_RX];
        // Status read clears, a same-cycle event still sets
        nxt_flag = tsp_pkg::tsp_ev_t'((rd_clr ? 3'h0 : flag_ff) | (ev_i & ~pd_i));
        nxt_irq = |(flag_ff & en_w);
    end

    // Flag and interrupt registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            flag_ff <= 3'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            flag_ff <= nxt_flag;
            irq_ff <= nxt_irq;
        end
    end

    // ========================================================
    // Outputs from flops, irq_n_o tied to a constant 0; pin level only ever low
    assign irq_n_o = 1'b0;
    assign irq_n_oe = irq_ff;
    assign reply_data = rout_ff;
    assign reply_oe = roe_ff;
    assign audio_sw_en = ctrl_ff[tsp_pkg::CTRL_AUDIO_SW];
    assign sum_sw_close = ctrl_ff[tsp_pkg::CTRL_SUM_SW];
    assign beep_cue_out = tone2_ff[tsp_pkg::TONE2_CUE_SEL];
    assign tone1_word = tone1_ff;
    assign tone2_word = tone2_ff;

    // ========================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_cmd_last;
        !cs_hi && rise && state_ff == tsp_pkg::S_CMD && bit_ff == 3'h7;
    endsequence
    sequence s_data_last;
        !cs_hi && rise && state_ff == tsp_pkg::S_DATA && bit_ff == 3'h7;
    endsequence

    chk_reply_hiz: assert property (cs_hi |=> !reply_oe)
        else $error("reply driven while deselected");
    chk_abort_idle: assert property ($rose(cs_hi) |=> state_ff == tsp_pkg::S_IDLE)
        else $error("deselect did not return to idle");
    chk_shift_msb: assert property (!cs_hi && rise && state_ff == tsp_pkg::S_CMD |=> sh_ff[0] == $past(din))
        else $error("command bit not shifted in");
    chk_reply_first: assert property (s_cmd_last ##0 (byte_w == tsp_pkg::CMD_RD_STATUS) |=> reply_oe && reply_data == $past(status_w[7]))
        else $error("status reply did not start");
    chk_irq_follow: assert property (|(flag_ff & en_w) |=> !irq_n_o && irq_n_oe)
        else $error("interrupt not asserted");
    chk_pd_quiet: assert property ((&pd_i) ##1 (&pd_i) |=> !irq_n_oe)
        else $error("interrupt from powered-down source");
    chk_pd_noflag: assert property (pd_i.gp && !flag_ff.gp |=> !flag_ff.gp)
        else $error("powered-down timer set its flag");
    chk_flag_set: assert property (ev_i.rx && !pd_i.rx |=> flag_ff.rx)
        else $error("measurement flag not set");
    chk_ctrl_write: assert property (s_data_last ##0 (cmd_ff == tsp_pkg::CMD_WR_CTRL) |=> audio_sw_en == $past(byte_w[7]) && sum_sw_close == $past(byte_w[4]))
        else $error("control byte not applied");
    chk_tone2_write: assert property (s_data_last ##0 (cmd_ff == tsp_pkg::CMD_WR_TONE2 && first_ff) |=> tone2_word == {$past(hi_ff), $past(byte_w)})
        else $error("tone word not applied");
endmodule
`default_nettype wire

// ### rtl/tsp_pkg.sv
// Constants and types shared by the tone signalling host port.
// Assumes a single core clock; the serial link pins are asynchronous to it.
package tsp_pkg;
    // ========================================================
    // Serial framing
    localparam int BYTE_W = 8;
    localparam int SYNC_STAGES = 2;
    localparam int LINK_CLK_NS = 200;
    // ========================================================
    // Command codes (first byte of each transfer)
    localparam logic [7:0] CMD_WR_CTRL = 8'h30;
    localparam logic [7:0] CMD_WR_TONE1 = 8'h31;
    localparam logic [7:0] CMD_WR_TONE2 = 8'h32;
    localparam logic [7:0] CMD_RD_STATUS = 8'h40;
    // ========================================================
    // Control byte fields
    localparam int CTRL_SUM_SW = 4;
    localparam int CTRL_EN_TMR = 5;
    localparam int CTRL_EN_RX = 6;
    localparam int CTRL_AUDIO_SW = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // ========================================================
    // Tone generator words
    localparam int TONE_W = 16;
    localparam int TONE2_CUE_SEL = 14;
    localparam logic [15:0] TONE_RST = 16'h0000;
    // ========================================================
    // Status byte fields
    localparam int ST_GP = 7;
    localparam int ST_NOTONE = 6;
    localparam int ST_RX = 5;
    localparam int ST_LOGIC = 0;
    // ========================================================
    // Types
    typedef struct packed {
        logic gp;
        logic notone;
        logic rx;
    } tsp_ev_t;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_CMD = 5'h02,
        S_DATA = 5'h04,
        S_REPLY = 5'h08,
        S_HOLD = 5'h10
    } tsp_state_t;
endpackage

// ### sim/tsp_host_mdl.sv
// Host microcontroller model for the tone signalling serial link.
// Assumes mclk paces the link; sclk idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module tsp_host_mdl
(
    // Pacing clock
    input wire logic mclk,
    // Serial link pins
    output logic sclk,
    output logic cs_n,
    output logic cmd_data,
    input wire logic reply_pin
);
    // ========================================================
    // Link pacing
    localparam int HALF = tsp_pkg::LINK_CLK_NS / 50; // Half link period in 25 ns mclk cycles

    initial
    begin
        sclk = 1'b0;
        cs_n = 1'b1;
        cmd_data = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // Shift the top n bits of tx, MSB first; reply is sampled just after each rise
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--)
        begin
            cmd_data <= tx[i];
            tick(HALF);
            sclk <= 1'b1;
            tick(1);
            #1 rx[i] = reply_pin;
            tick(HALF - 1);
            sclk <= 1'b0;
        end
    endtask

    // One framed transfer; last byte may be cut short to abandon it
    task automatic xfer(input logic [7:0] cmd, input int nb, input logic [15:0] dat,
                        input int last_bits, output logic [7:0] rx);
        logic [7:0] b [3];
        b[0] = cmd;
        b[1] = (nb == 2) ? dat[15:8] : dat[7:0];
        b[2] = dat[7:0];
        cs_n <= 1'b0;
        tick(HALF);
        for (int k = 0; k <= nb; k++)
        begin
            shift(b[k], (k == nb) ? last_bits : 8, rx);
        end
        tick(HALF);
        cs_n <= 1'b1;
        cmd_data <= ~cmd_data; // Released line must not hold its last value
        tick(HALF);
    endtask
endmodule
`default_nettype wire

// ### sim/tsp_host_port_test.sv
// Self-checking bench for the tone signalling host port.
// Assumes the host model in tsp_host_mdl drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tsp_host_port_test;
    // ========================================================
    // Stimulus and wiring
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic logic_in = 1'b0;
    tsp_pkg::tsp_ev_t ev_i = '0;
    tsp_pkg::tsp_ev_t pd_i = '0;
    wire logic sclk;
    wire logic cs_n;
    wire logic cmd_data;
    logic reply_data, reply_oe, irq_n_o, irq_n_oe, audio_sw_en, sum_sw_close, beep_cue_out;
    logic [15:0] tone1_word, tone2_word;
    logic [7:0] rx;
    int error_cnt = 0;
    int checked = 0;
    // Reply floats when not driven; interrupt line has a pull-up
    wire logic reply_pin = reply_oe ? reply_data : 1'bz;
    wire logic irq_pin = irq_n_oe ? irq_n_o : 1'b1;

    always #12.5 mclk = ~mclk;

    tsp_host_port tsp_host_port_inst (.mclk(mclk), .reset_n(reset_n), .sclk(sclk),
        .cs_n(cs_n), .cmd_data(cmd_data), .reply_data(reply_data), .reply_oe(reply_oe),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .logic_in(logic_in), .ev_i(ev_i),
        .pd_i(pd_i), .audio_sw_en(audio_sw_en), .sum_sw_close(sum_sw_close),
        .beep_cue_out(beep_cue_out), .tone1_word(tone1_word), .tone2_word(tone2_word));
    tsp_host_mdl tsp_host_mdl_inst (.mclk(mclk), .sclk(sclk), .cs_n(cs_n),
        .cmd_data(cmd_data), .reply_pin(reply_pin));

    // ========================================================
    // Helpers
    task automatic xf(input logic [7:0] c, input int nb, input logic [15:0] d, input int lb);
        tsp_host_mdl_inst.xfer(c, nb, d, lb, rx);
    endtask

    // One-cycle event pulse, then let flag and interrupt settle
    task automatic pulse(input tsp_pkg::tsp_ev_t e);
        ev_i <= e;
        @(posedge mclk);
        ev_i <= '0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ========================================================
    // Scenarios
    task automatic t_reset;
        `CHK("reset_outs", 37'h0, {reply_oe, irq_n_oe, audio_sw_en, sum_sw_close,
            beep_cue_out, tone1_word, tone2_word})
        $display("test reset done");
    endtask

    // Each switch bit lands on its own output
    task automatic t_ctrl;
        logic [7:0] v [3] = '{8'h90, 8'h80, 8'h10};
        for (int i = 0; i < 3; i++)
        begin
            xf(tsp_pkg::CMD_WR_CTRL, 1, {8'h00, v[i]}, 8);
            `CHK("ctrl_sw", {v[i][7], v[i][4]}, {audio_sw_en, sum_sw_close})
        end
        $display("test ctrl done");
    endtask

    task automatic t_tone;
        xf(tsp_pkg::CMD_WR_TONE1, 2, 16'ha5c3, 8);
        xf(tsp_pkg::CMD_WR_TONE2, 2, 16'h4001, 8);
        `CHK("tone1", 16'ha5c3, tone1_word)
        `CHK("tone2", 16'h4001, tone2_word)
        `CHK("cue_sel", 1'b1, beep_cue_out)
        xf(tsp_pkg::CMD_WR_TONE2, 2, 16'hbffe, 8);
        `CHK("cue_sel", 1'b0, beep_cue_out)
        $display("test tone done");
    endtask

    // Transfers cut short must leave everything as it was
    task automatic t_abort;
        xf(tsp_pkg::CMD_WR_CTRL, 1, 16'h0080, 8);
        xf(tsp_pkg::CMD_WR_CTRL, 1, 16'h0000, 4);
        `CHK("abort_ctrl", 1'b1, audio_sw_en)
        xf(8'h55, 1, 16'h0000, 8);
        `CHK("unknown_cmd", 1'b1, audio_sw_en)
        xf(tsp_pkg::CMD_WR_TONE1, 1, 16'h0012, 8);
        `CHK("abort_tone", 16'ha5c3, tone1_word)
        xf(tsp_pkg::CMD_WR_CTRL, 0, 16'h0000, 3);
        xf(tsp_pkg::CMD_WR_CTRL, 1, 16'h0000, 8);
        `CHK("after_abort", 1'b0, audio_sw_en)
        $display("test abort done");
    endtask

    task automatic t_status;
        xf(tsp_pkg::CMD_WR_CTRL, 1, 16'h0060, 8);
        logic_in <= 1'b1;
        pulse(3'b101);
        `CHK("irq_on", 1'b0, irq_pin)
        `CHK("reply_idle", 1'b0, reply_oe)
        xf(tsp_pkg::CMD_RD_STATUS, 1, 16'h0000, 8);
        `CHK("status", 8'ha1, rx)
        `CHK("irq_off", 1'b1, irq_pin)
        `CHK("reply_done", 1'b0, reply_oe)
        logic_in <= 1'b0;
        xf(tsp_pkg::CMD_RD_STATUS, 1, 16'h0000, 8);
        `CHK("status_live", 8'h00, rx)
        $display("test status done");
    endtask

    // Masked source flags without interrupt; powered-down source does nothing
    task automatic t_mask;
        xf(tsp_pkg::CMD_WR_CTRL, 1, 16'h0000, 8);
        pulse(3'b010);
        `CHK("masked", 1'b1, irq_pin)
        pd_i <= 3'b100;
        pulse(3'b100);
        xf(tsp_pkg::CMD_RD_STATUS, 1, 16'h0000, 8);
        `CHK("status_pd", 8'h40, rx)
        xf(tsp_pkg::CMD_WR_CTRL, 1, 16'h0020, 8);
        pd_i <= 3'b111;
        pulse(3'b111);
        `CHK("pd_quiet", 1'b1, irq_pin)
        pd_i <= 3'b000;
        pulse(3'b100);
        `CHK("tmr_irq", 1'b0, irq_pin)
        xf(tsp_pkg::CMD_RD_STATUS, 1, 16'h0000, 8);
        `CHK("status_gp", 8'h80, rx)
        $display("test mask done");
    endtask

    // ========================================================
    // Main sequence and watchdog
    initial
    begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        t_reset();
        t_ctrl();
        t_tone();
        t_abort();
        t_status();
        t_mask();
        end_sim();
    end

    // Whole run needs about 2750 cycles; this leaves wide margin
    initial
    begin
        repeat (40000) @(posedge mclk);
        error_cnt++;
        $display("[ERR] watchdog expired");
        end_sim();
    end
endmodule
`default_nettype wire
